// ---- inc/pmem_regs.svh ----
`ifndef PMEM_REGS_SVH
`define PMEM_REGS_SVH

// Word address of the first instruction after reset
`define RESET_VECTOR      13'h0000
// High pointer value used by the last-page table read forms
`define LAST_PAGE_HI      5'h1f
// Low and high pointer fields of the table word address
`define PTR_LO_MSB        7
`define PTR_LO_LSB        0
`define PTR_HI_MSB        12
`define PTR_HI_LSB        8
// Reset values of the pointers and the high byte latch
`define PTR_LO_RESET      8'h00
`define PTR_HI_RESET      5'h00
`define HIGH_LATCH_RESET  8'h00
// Clock phases per instruction cycle and table op length in cycles
`define PHASES_PER_CYCLE  4
`define TABLE_OP_CYCLES   2
// Phase counter value entered by reset, so the first edge opens a cycle
`define PHASE_RESET       2'h3

`endif

// ---- inc/pmem_pkg.sv ----
package pmem_pkg;

    typedef enum logic [1:0] {
        table_read_op                    = 2'h0,
        table_read_last_page_op          = 2'h1,
        extended_table_read_op           = 2'h2,
        extended_table_read_last_page_op = 2'h3
    } table_op_type;

    // Gray sequence idle -> first -> second
    typedef enum logic [1:0] {
        st_idle   = 2'h0,
        st_first  = 2'h1,
        st_second = 2'h3
    } table_state_type;

endpackage : pmem_pkg

// ---- logic/cycle_phase_gen.sv ----
`timescale 1ns/10ps
`include "pmem_regs.svh"

module cycle_phase_gen (
    input  wire logic       clk,
    input  wire logic       rst_b,
    output logic [3:0]      cycle_phases,
    output logic            cycle_end
);
    logic [1:0] phase_q;

    // Four phases per instruction cycle, one-hot out
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= `PHASE_RESET;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    always_comb begin
        cycle_phases = 4'h0;
        cycle_phases[phase_q] = 1'b1;
    end

    // Last phase: the next edge opens a new cycle
    assign cycle_end = (phase_q == 2'(`PHASES_PER_CYCLE - 1));

endmodule : cycle_phase_gen

// ---- logic/program_memory_table_read.sv ----
// Operation
// - Program memory holds 8K words of 16 bits, fetched by the counter.
// - After reset, the first fetch is from word address zero.
// - Table reads use a low and high pointer pair, not the counter.
// - Low byte of the table word goes to the operand data register.
// - High byte goes to a software read/write holding latch.
// - Every table instruction takes two instruction cycles.
// - Basic forms reach sector 0 only; extended forms reach any sector.
// - Four phases per cycle; fetch and increment open the first phase.
`timescale 1ns/10ps
`include "pmem_regs.svh"

module program_memory_table_read #(
    parameter int ADDR_W   = 13,
    parameter int WORDS    = 8192,
    parameter int SECTOR_W = 3
) (
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    // Instruction fetch towards the core
    input  wire logic                      pc_load,
    input  wire logic [ADDR_W-1:0]         pc_load_addr,
    output logic [ADDR_W-1:0]              pc,
    output logic [15:0]                    instr,
    output logic                           instr_valid,
    output logic [3:0]                     cycle_phases,
    output logic                           stall,
    // Pointer and high latch access from the core
    input  wire logic                      ptr_lo_wr,
    input  wire logic                      ptr_hi_wr,
    input  wire logic                      high_latch_wr,
    input  wire logic [7:0]                core_wr_data,
    output logic [7:0]                     ptr_lo,
    output logic [4:0]                     ptr_hi,
    output logic [7:0]                     table_high_byte_latch,
    // Table read request, sampled at the start of an instruction cycle
    input  wire logic                      table_req,
    input  wire pmem_pkg::table_op_type    table_op,
    input  wire logic [SECTOR_W+7:0]       table_operand,
    output logic                           table_busy,
    // Operand write towards data memory
    output logic                           dm_wr_en,
    output logic [SECTOR_W+7:0]            dm_wr_addr,
    output logic [7:0]                     dm_wr_data,
    // Contents load from the programming engine
    input  wire logic                      load_en,
    input  wire logic [ADDR_W-1:0]         load_addr,
    input  wire logic [15:0]               load_data
);
    import pmem_pkg::*;

    logic [15:0]             mem_q [WORDS];
    logic [ADDR_W-1:0]       pc_q;
    logic [15:0]             instr_q;
    logic                    instr_valid_q;
    logic [7:0]              ptr_lo_q;
    logic [4:0]              ptr_hi_q;
    logic [7:0]              high_q;
    table_state_type         state_q;
    table_state_type         state_d;
    logic [ADDR_W-1:0]       tbl_addr_q;
    logic [SECTOR_W+7:0]     operand_q;
    logic                    dm_wr_en_q;
    logic [SECTOR_W+7:0]     dm_wr_addr_q;
    logic [7:0]              dm_wr_data_q;
    logic                    cycle_end;
    logic                    start;
    logic                    finish;
    logic [15:0]             tbl_word;

    // Word address from an op and the pointer pair
    function automatic logic [ADDR_W-1:0] table_addr(
        input table_op_type op,
        input logic [7:0]   lo,
        input logic [4:0]   hi
    );
        logic [4:0] page;
        page = hi;
        if (op == table_read_last_page_op ||
            op == extended_table_read_last_page_op) begin
            page = `LAST_PAGE_HI;
        end
        table_addr = ADDR_W'({page, lo});
    endfunction : table_addr

    // Operand location; basic forms carry no sector bits
    function automatic logic [SECTOR_W+7:0] operand_addr(
        input table_op_type        op,
        input logic [SECTOR_W+7:0] opnd
    );
        if (op == table_read_op || op == table_read_last_page_op) begin
            operand_addr = {{SECTOR_W{1'b0}}, opnd[7:0]};
        end else begin
            operand_addr = opnd;
        end
    endfunction : operand_addr

    cycle_phase_gen u_phase (
        .clk          (clk),
        .rst_b        (rst_b),
        .cycle_phases (cycle_phases),
        .cycle_end    (cycle_end)
    );

    // Requests are only taken as a new instruction cycle opens
    assign start  = cycle_end && table_req &&
                    (state_q == st_idle || state_q == st_second);
    assign finish = cycle_end && state_q == st_second;

    // Storage has no reset: contents survive a device reset
    always_ff @(posedge clk) begin
        if (load_en) begin
            mem_q[load_addr] <= load_data;
        end
    end

    assign tbl_word = mem_q[tbl_addr_q];

    // Fetch and increment as the first phase opens
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_q          <= `RESET_VECTOR;
            instr_q       <= 16'h0000;
            instr_valid_q <= 1'b0;
        end else if (cycle_end) begin
            if (state_q == st_first) begin
                // Dummy slot: the second table cycle fetches nothing
                instr_valid_q <= 1'b0;
            end else if (pc_load) begin
                instr_q       <= mem_q[pc_load_addr];
                pc_q          <= pc_load_addr + ADDR_W'(1);
                instr_valid_q <= 1'b1;
            end else begin
                instr_q       <= mem_q[pc_q];
                pc_q          <= pc_q + ADDR_W'(1);
                instr_valid_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ptr_lo_q <= `PTR_LO_RESET;
            ptr_hi_q <= `PTR_HI_RESET;
        end else begin
            if (ptr_lo_wr) begin
                ptr_lo_q <= core_wr_data;
            end
            if (ptr_hi_wr) begin
                ptr_hi_q <= core_wr_data[4:0];
            end
        end
    end

    always_comb begin
        case (state_q)
            st_idle:   state_d = start ? st_first : st_idle;
            st_first:  state_d = cycle_end ? st_second : st_first;
            st_second: begin
                if (cycle_end) begin
                    state_d = start ? st_first : st_idle;
                end else begin
                    state_d = st_second;
                end
            end
            default:   state_d = st_idle;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= st_idle;
        end else begin
            state_q <= state_d;
        end
    end

    // Address latched at start, so pointer writes after it do not disturb
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tbl_addr_q <= `RESET_VECTOR;
            operand_q  <= '0;
        end else if (start) begin
            tbl_addr_q <= table_addr(table_op, ptr_lo_q, ptr_hi_q);
            operand_q  <= operand_addr(table_op, table_operand);
        end
    end

    // Operand write at the close of the second cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dm_wr_en_q   <= 1'b0;
            dm_wr_addr_q <= '0;
            dm_wr_data_q <= 8'h00;
        end else begin
            dm_wr_en_q <= finish;
            if (finish) begin
                dm_wr_addr_q <= operand_q;
                dm_wr_data_q <= tbl_word[7:0];
            end
        end
    end

    // Hardware load beats a software write in the same edge
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            high_q <= `HIGH_LATCH_RESET;
        end else if (finish) begin
            high_q <= tbl_word[15:8];
        end else if (high_latch_wr) begin
            high_q <= core_wr_data;
        end
    end

    assign pc                    = pc_q;
    assign instr                 = instr_q;
    assign instr_valid           = instr_valid_q;
    assign stall                 = (state_q == st_first);
    assign ptr_lo                = ptr_lo_q;
    assign ptr_hi                = ptr_hi_q;
    assign table_high_byte_latch = high_q;
    assign table_busy            = (state_q != st_idle);
    assign dm_wr_en              = dm_wr_en_q;
    assign dm_wr_addr            = dm_wr_addr_q;
    assign dm_wr_data            = dm_wr_data_q;

endmodule : program_memory_table_read

// ---- verification/pmem_checker_sva.sv ----
`timescale 1ns/10ps
module pmem_checker #(
    parameter int ADDR_W   = 13,
    parameter int SECTOR_W = 3
) (
    input wire logic                   clk,
    input wire logic                   rst_b,
    input wire logic                   pc_load,
    input wire logic [ADDR_W-1:0]      pc,
    input wire logic                   instr_valid,
    input wire logic [3:0]             cycle_phases,
    input wire logic                   stall,
    input wire logic                   ptr_lo_wr,
    input wire logic [7:0]             core_wr_data,
    input wire logic [7:0]             ptr_lo,
    input wire logic                   table_req,
    input wire pmem_pkg::table_op_type table_op,
    input wire logic [SECTOR_W+7:0]    table_operand,
    input wire logic                   table_busy,
    input wire logic                   dm_wr_en,
    input wire logic [SECTOR_W+7:0]    dm_wr_addr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    phase_one_hot_a: assert property ($onehot(cycle_phases))
        else $error("phase not one-hot");
    phase_wrap_a: assert property (
        cycle_phases[3] |=> cycle_phases == 4'h1)
        else $error("last phase not followed by first");
    fetch_step_a: assert property (
        cycle_phases[3] && !stall && !pc_load
        |=> pc == $past(pc) + 1'b1 && instr_valid)
        else $error("fetch did not advance pc");
    dummy_slot_a: assert property (cycle_phases[3] && stall
        |=> !instr_valid && $stable(pc))
        else $error("fetch during table slot");
    take_busy_a: assert property (
        cycle_phases[3] && table_req && !table_busy
        |=> table_busy && stall)
        else $error("table request not taken");
    busy_span_a: assert property ($rose(table_busy)
        |-> table_busy [*8] ##1 dm_wr_en)
        else $error("table op length wrong");
    write_pulse_a: assert property (dm_wr_en |=> !dm_wr_en)
        else $error("operand write longer than a clock");
    basic_sector_a: assert property (
        dm_wr_en && !$past(table_op[1], 9)
        |-> dm_wr_addr[SECTOR_W+7:8] == '0)
        else $error("basic form left sector 0");
    operand_addr_a: assert property (dm_wr_en
        |-> dm_wr_addr[7:0] == $past(table_operand[7:0], 9))
        else $error("operand address wrong");
    ptr_write_a: assert property (
        ptr_lo_wr |=> ptr_lo == $past(core_wr_data))
        else $error("pointer low not written");
endmodule : pmem_checker

bind program_memory_table_read pmem_checker #(
    .ADDR_W(ADDR_W), .SECTOR_W(SECTOR_W)
) i_pmem_checker (.clk, .rst_b, .pc_load, .pc, .instr_valid, .cycle_phases,
    .stall, .ptr_lo_wr, .core_wr_data, .ptr_lo, .table_req, .table_op,
    .table_operand, .table_busy, .dm_wr_en, .dm_wr_addr);

// ---- verification/data_memory_model.sv ----
`timescale 1ns/10ps
module data_memory_model (
    input wire logic        clk,
    input wire logic        dm_wr_en,
    input wire logic [10:0] dm_wr_addr,
    input wire logic [7:0]  dm_wr_data
);
    logic [7:0] mem [2048];
    // Operand register file of the core
    always_ff @(posedge clk) begin
        if (dm_wr_en) begin
            mem[dm_wr_addr] <= dm_wr_data;
        end
    end
endmodule : data_memory_model

// ---- verification/program_memory_table_read_test.sv ----
`timescale 1ns/10ps
module program_memory_table_read_test;
    import pmem_pkg::*;
    logic         clk = 0, rst_b = 0, instr_valid, stall, table_busy, dm_wr_en;
    logic         ptr_lo_wr = 0, ptr_hi_wr = 0, high_latch_wr = 0;
    logic         table_req = 0, load_en = 0, pc_load = 0;
    logic [12:0]  pc, load_addr = '0, pc_load_addr = '0;
    logic [15:0]  instr, load_data = '0;
    logic [3:0]   cycle_phases;
    logic [7:0]   core_wr_data = '0, ptr_lo, table_high_byte_latch, dm_wr_data;
    logic [4:0]   ptr_hi;
    logic [10:0]  table_operand = '0, dm_wr_addr;
    table_op_type table_op = table_read_op;
    int           n_errors = 0, compares = 0;
    always #25 clk = ~clk;
    program_memory_table_read i_program_memory_table_read (.clk, .rst_b,
        .pc_load, .pc_load_addr, .pc, .instr, .instr_valid,
        .cycle_phases, .stall, .ptr_lo_wr, .ptr_hi_wr, .high_latch_wr,
        .core_wr_data, .ptr_lo, .ptr_hi, .table_high_byte_latch, .table_req,
        .table_op, .table_operand, .table_busy, .dm_wr_en, .dm_wr_addr,
        .dm_wr_data, .load_en, .load_addr, .load_data);
    data_memory_model i_data_memory_model (.clk, .dm_wr_en, .dm_wr_addr,
        .dm_wr_data);
    function automatic logic [15:0] word(logic [12:0] a);
        return {a[7:0] ^ 8'ha5, a[12:5]};
    endfunction : word
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("mismatches %0d of %0d compares", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic load_one(logic [12:0] a);
        load_en = 1;
        load_addr = a;
        load_data = word(a);
        tick(1);
        load_en = 0;
    endtask : load_one
    task automatic wr(int which, logic [7:0] d);
        core_wr_data = d;
        ptr_lo_wr = (which == 0);
        ptr_hi_wr = (which == 1);
        high_latch_wr = (which == 2);
        tick(1);
        {ptr_lo_wr, ptr_hi_wr, high_latch_wr} = 3'h0;
        // An idle edge between strobes keeps one write per edge
        tick(1);
    endtask : wr
    task automatic t_reset();
        // Load runs under reset; enable held across the whole burst
        load_en = 1;
        for (int i = 0; i < 20; i++) begin
            load_addr = 13'(i);
            load_data = word(13'(i));
            tick(1);
        end
        load_en = 0;
        rst_b = 1;
        tick(1);
        chk("instr", word(13'h0000), instr);
        chk("pc", 16'h0001, {3'h0, pc});
        tick(4);
        chk("instr", word(13'h0001), instr);
        chk("valid", 16'h0001, {15'h0, instr_valid});
    endtask : t_reset
    task automatic t_regs();
        wr(0, 8'h3c);
        wr(1, 8'h15);
        wr(2, 8'h77);
        chk("ptr", 16'h153c, {3'h0, ptr_hi, ptr_lo});
        chk("latch", 16'h0077, {8'h0, table_high_byte_latch});
    endtask : t_regs
    task automatic wait_end();
        int i;
        for (i = 0; i < 8 && cycle_phases !== 4'h8; i++) tick(1);
        if (cycle_phases !== 4'h8) n_errors++;
    endtask : wait_end
    task automatic t_jump();
        wait_end();
        pc_load = 1;
        pc_load_addr = 13'h0005;
        tick(1);
        pc_load = 0;
        chk("instr", word(13'h0005), instr);
        chk("pc", 16'h0006, {3'h0, pc});
    endtask : t_jump
    task automatic tread(table_op_type op, logic [7:0] lo, logic [4:0] hi,
                         logic [10:0] opnd);
        logic [12:0] a;
        logic [15:0] w;
        logic [10:0] da;
        a = {(op[0] ? 5'h1f : hi), lo};
        w = word(a);
        da = {(op[1] ? opnd[10:8] : 3'h0), opnd[7:0]};
        load_one(a);
        wr(0, lo);
        wr(1, {3'h0, hi});
        wait_end();
        table_req = 1;
        table_op = op;
        table_operand = opnd;
        tick(1);
        table_req = 0;
        chk("busy", 16'h0001, {15'h0, table_busy});
        tick(4);
        chk("valid", 16'h0000, {15'h0, instr_valid});
        tick(4);
        chk("dm_en", 16'h0001, {15'h0, dm_wr_en});
        chk("dm_data", {8'h0, w[7:0]}, {8'h0, dm_wr_data});
        chk("dm_addr", {5'h0, da}, {5'h0, dm_wr_addr});
        chk("latch", {8'h0, w[15:8]}, {8'h0, table_high_byte_latch});
        tick(1);
        chk("dm_mem", 16'(w[7:0]), 16'(i_data_memory_model.mem[da]));
    endtask : tread
    initial begin
        t_reset();
        t_regs();
        t_jump();
        for (int k = 0; k < 4; k++) begin
            tread(table_op_type'(k), 8'h06 + 8'(k), 5'h0a,
                  11'h5c3 + 11'(k));
        end
        report_and_stop();
    end
endmodule : program_memory_table_read_test
